// ===== rtl/alu_ops_params.svh
// Constants for the subtract, nibble-swap and direction-load datapath.
// Assumes the core decoder presents one 14-bit word per instruction cycle.
`ifndef ALU_OPS_PARAMS_SVH
`define ALU_OPS_PARAMS_SVH

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define OPC_SUB_TOP 6'h02
`define OPC_SWAP_TOP 6'h0e
// Direction-load opcode is owned by the full instruction map
`define OPC_DIR_BASE 14'h0060
`define OPC_DIR_MASK 14'h3ff8
`define DEST_BIT 7
`define DIR_SEL_LO 3'h5
`define DIR_SEL_HI 3'h7
// Direction registers also sit in the file at these addresses
`define DIR_ADDR_BASE 7'h05
`define DIR_RESET 8'hff
`define ACC_RESET 8'h00

`endif

// ===== rtl/alu_ops_pkg.sv
// Types shared by the datapath and its users.
// Assumes the constants header is included beside it.
package alu_ops_pkg;
   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic zero;
   } flags_t;

   typedef struct packed {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
   } reg_write_t;

   typedef enum logic [1:0] {OP_NONE, OP_SUB, OP_SWAP, OP_DIR} op_t;
endpackage : alu_ops_pkg

// ===== rtl/alu_ops.sv
// Execution datapath for subtract, nibble swap and direction load.
// Assumes decoder gives one instruction per enabled clock with register data.
`timescale 1ns/1ps
`include "alu_ops_params.svh"
module alu_ops #(
   parameter int DATA_W = 8,
   parameter int N_DIR = 3
) (
   // Clock and control
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Instruction and register file read
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   input wire logic [7:0] reg_rdata,
   // Ordinary register file writes aimed at direction registers
   input wire logic file_wr_en,
   input wire logic [6:0] file_wr_addr,
   input wire logic [7:0] file_wr_data,
   // Results
   output alu_ops_pkg::reg_write_t reg_wr,
   output logic [7:0] acc,
   output alu_ops_pkg::flags_t flags,
   output logic flags_wr,
   output logic [23:0] dir_regs
);
   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   // Ports and flag logic are written for one byte and three registers
   if (DATA_W != 8) begin : g_bad_width
      $error("alu_ops serves only a data width of 8");
   end
   if (N_DIR != 3) begin : g_bad_count
      $error("alu_ops serves only three direction registers");
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic in_dir_file(input logic [6:0] a);
      return a >= `DIR_ADDR_BASE && a <= `DIR_ADDR_BASE + 7'h02;
   endfunction : in_dir_file

   // Offset from a base, cut to the slot of one direction register
   function automatic logic [1:0] dir_slot(input logic [6:0] a,
                                           input logic [6:0] base);
      logic [6:0] off;
      off = a - base;
      return off[1:0];
   endfunction : dir_slot

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic [5:0] top = instr[13:8];
   wire logic dest = instr[`DEST_BIT];
   wire logic [6:0] addr = instr[6:0];
   wire logic is_dir_pat = (instr & `OPC_DIR_MASK) == `OPC_DIR_BASE;
   wire logic [2:0] dir_sel = instr[2:0];
   wire logic dir_ok = dir_sel >= `DIR_SEL_LO && dir_sel <= `DIR_SEL_HI;
   alu_ops_pkg::op_t op;
   assign op = !instr_valid ? alu_ops_pkg::OP_NONE :
      top == `OPC_SUB_TOP ? alu_ops_pkg::OP_SUB :
      top == `OPC_SWAP_TOP ? alu_ops_pkg::OP_SWAP :
      (is_dir_pat && dir_ok) ? alu_ops_pkg::OP_DIR : alu_ops_pkg::OP_NONE;

   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   wire logic [8:0] diff = {1'b0, reg_rdata} - {1'b0, acc};
   wire logic [4:0] ldiff = {1'b0, reg_rdata[3:0]} - {1'b0, acc[3:0]};
   wire logic [7:0] swapped = {reg_rdata[3:0], reg_rdata[7:4]};
   wire logic [7:0] result = (op == alu_ops_pkg::OP_SUB) ? diff[7:0] : swapped;
   wire logic is_arith = op == alu_ops_pkg::OP_SUB || op == alu_ops_pkg::OP_SWAP;
   wire logic to_reg = is_arith && dest;
   wire logic to_acc = is_arith && !dest;
   alu_ops_pkg::flags_t next_flags;
   assign next_flags.carry = !diff[8];
   assign next_flags.half_carry_flag = !ldiff[4];
   assign next_flags.zero = diff[7:0] == 8'h00;
   wire logic dir_file_hit = file_wr_en && in_dir_file(file_wr_addr);
   wire logic [1:0] file_idx = dir_slot(file_wr_addr, `DIR_ADDR_BASE);
   wire logic [1:0] dir_idx = dir_slot({4'h0, dir_sel}, {4'h0, `DIR_SEL_LO});

   // ----------------------------------------------------------------
   // State, one instruction cycle per word
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         acc <= `ACC_RESET;
         flags <= '0;
         flags_wr <= 1'b0;
         reg_wr <= '0;
         dir_regs <= {3{`DIR_RESET}};
      end else if (ce) begin
         if (to_acc)
            acc <= result;
         reg_wr.en <= to_reg;
         reg_wr.addr <= addr;
         reg_wr.data <= result;
         flags_wr <= op == alu_ops_pkg::OP_SUB;
         if (op == alu_ops_pkg::OP_SUB)
            flags <= next_flags;
         // Instruction path wins over a same-cycle file write
         if (dir_file_hit)
            dir_regs[file_idx*8 +: 8] <= file_wr_data;
         if (op == alu_ops_pkg::OP_DIR)
            dir_regs[dir_idx*8 +: 8] <= acc;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_SUB_ACC: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB && !dest
      |=> acc == $past(reg_rdata) - $past(acc))
      else $error("subtract to accumulator wrong");
   AST_SUB_REG: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB && dest
      |=> reg_wr.en && reg_wr.data == $past(reg_rdata) - $past(acc)
          && acc == $past(acc))
      else $error("subtract to register wrong");
   AST_BORROW: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB |=>
      flags.carry == ($past(reg_rdata) >= $past(acc)))
      else $error("carry not borrow sense");
   AST_ZERO: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB && reg_rdata == acc
      |=> flags == 3'b111 && flags_wr)
      else $error("zero result flags wrong");
   AST_HALF: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB |=> flags.half_carry_flag ==
      ($past(reg_rdata[3:0]) >= $past(acc[3:0])))
      else $error("half carry wrong");
   AST_SWAP: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SWAP |=> $stable(flags) && !flags_wr)
      else $error("swap altered flags");
   AST_SWAP_DEST: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SWAP && !dest |=> !reg_wr.en
      && acc == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])})
      else $error("swap to accumulator wrong");
   AST_DIR: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_DIR |=> $stable(flags) && !reg_wr.en
      && dir_regs[$past(dir_idx)*8 +: 8] == $past(acc))
      else $error("direction load wrong");
   AST_DIR_FILE: assert property (@(posedge clock) disable iff (rst)
      ce && dir_file_hit && op != alu_ops_pkg::OP_DIR
      |=> dir_regs[$past(file_idx)*8 +: 8] == $past(file_wr_data))
      else $error("direction file write lost");

   AST_SUB_ADDR: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB && dest |=> reg_wr.addr == $past(addr))
      else $error("subtract write-back address wrong");

   AST_SUB_KEEP: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB && !dest |=> !reg_wr.en)
      else $error("subtract to accumulator wrote register");

   AST_ACC_KEEP: assert property (@(posedge clock) disable iff (rst)
      ce && !to_acc |=> $stable(acc))
      else $error("accumulator changed without a write");

   AST_SUB_NEG: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB && reg_rdata < acc
      |=> !flags.carry && !flags.zero)
      else $error("negative difference flags wrong");

   AST_ZERO_CLR: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SUB && reg_rdata != acc
      |=> !flags.zero && flags_wr)
      else $error("nonzero difference set zero");

   AST_NO_FLAGS: assert property (@(posedge clock) disable iff (rst)
      ce && op != alu_ops_pkg::OP_SUB |=> !flags_wr)
      else $error("flags written outside subtract");

   AST_SWAP_REG: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_SWAP && dest
      |=> reg_wr.en && reg_wr.addr == $past(addr)
      && reg_wr.data == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])}
      && acc == $past(acc))
      else $error("swap to register wrong");

   AST_DIR_ACC: assert property (@(posedge clock) disable iff (rst)
      ce && op == alu_ops_pkg::OP_DIR |=> !flags_wr && $stable(acc))
      else $error("direction load touched accumulator");

   // Operand outside the three registers must leave write-back, flags and accumulator alone
   AST_DIR_REFUSE: assert property (@(posedge clock) disable iff (rst)
      ce && instr_valid && is_dir_pat && !dir_ok
      |=> !reg_wr.en && !flags_wr && $stable(acc) && $stable(flags))
      else $error("refused direction load acted");

   AST_DIR_QUIET: assert property (@(posedge clock) disable iff (rst)
      ce && !dir_file_hit && op != alu_ops_pkg::OP_DIR |=> $stable(dir_regs))
      else $error("direction register changed unasked");

   // ----------------------------------------------------------------
   // Enable and reset checks
   // ----------------------------------------------------------------
   AST_CE_HOLD: assert property (@(posedge clock) disable iff (rst)
      !ce |=> $stable(acc) && $stable(flags) && $stable(flags_wr)
      && $stable(reg_wr) && $stable(dir_regs))
      else $error("state moved while enable low");

   AST_PULSE: assert property (@(posedge clock) disable iff (rst)
      ce && !to_reg |=> !reg_wr.en)
      else $error("write-back strobe stayed high");

   // Reset wins over the enable, so no disable here
   AST_RESET: assert property (@(posedge clock)
      rst |=> acc == `ACC_RESET && flags == 3'h0 && !flags_wr
      && !reg_wr.en && dir_regs == {3{`DIR_RESET}})
      else $error("reset values wrong");
endmodule : alu_ops

// ===== bench/reg_file_model.sv
// Partner register file: answers reads at once, keeps write-backs.
// Assumes the bench fills it before the first instruction.
`timescale 1ns/1ps
module reg_file_model (
   // Clock
   input wire logic clock,
   // Read port, combinational like the real file
   input wire logic [6:0] raddr,
   output logic [7:0] rdata,
   // Write-back from the datapath
   input wire alu_ops_pkg::reg_write_t wr
);
   logic [7:0] mem [128];
   assign rdata = mem[raddr];
   always @(posedge clock) begin
      if (wr.en)
         mem[wr.addr] <= wr.data;
   end
endmodule : reg_file_model

// ===== bench/subtract_swap_direction_ops_tb.sv
// Self-checking bench for the subtract, swap and direction-load datapath.
// Assumes alu_ops and the register file partner are compiled first.
`timescale 1ns/1ps
module subtract_swap_direction_ops_tb;
   logic clock = 0, rst = 1, ce = 0, instr_valid = 0, file_wr_en = 0;
   logic [13:0] instr = 14'h0;
   logic [6:0] file_wr_addr = 7'h0;
   logic [7:0] file_wr_data = 8'h0, reg_rdata, acc, exp_acc = 8'h0;
   logic flags_wr;
   logic [23:0] dir_regs, exp_dir = 24'hffffff;
   logic [15:0] exp_rw = 16'h0;
   logic [3:0] exp_fl = 4'h0;
   alu_ops_pkg::reg_write_t reg_wr;
   alu_ops_pkg::flags_t flags;
   logic [51:0] q [$];
   int errors = 0, n_compared = 0, seen = 0;
   // Address and data are only meaningful while the write strobe is up
   wire [15:0] got_rw = reg_wr.en ? reg_wr : 16'h0;
   always #25 clock = ~clock;
   alu_ops u_dut (.clock(clock), .rst(rst), .ce(ce),
      .instr_valid(instr_valid), .instr(instr), .reg_rdata(reg_rdata),
      .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
      .file_wr_data(file_wr_data), .reg_wr(reg_wr), .acc(acc),
      .flags(flags), .flags_wr(flags_wr), .dir_regs(dir_regs));
   reg_file_model u_rf (.clock(clock), .raddr(instr[6:0]),
      .rdata(reg_rdata), .wr(reg_wr));
   task automatic step(input logic [13:0] w, input logic v, input logic c,
                       input logic fw, input logic [7:0] fd);
      logic [7:0] r;
      logic [7:0] res;
      logic sub;
      logic swp;
      logic dir;
      @(posedge clock);
      instr <= w;
      instr_valid <= v;
      ce <= c;
      file_wr_en <= fw;
      file_wr_addr <= {4'h0, w[2:0]};
      file_wr_data <= fd;
      #1;
      r = u_rf.mem[w[6:0]];
      sub = v && w[13:8] == 6'h02;
      swp = v && w[13:8] == 6'h0e;
      dir = v && (w & 14'h3ff8) == 14'h0060 && w[2:0] >= 3'h5;
      res = sub ? r - exp_acc : {r[3:0], r[7:4]};
      if (c) begin
         if (fw && w[2:0] >= 3'h5)
            exp_dir[(int'(w[2:0]) - 5) * 8 +: 8] = fd;
         if (dir)
            exp_dir[(int'(w[2:0]) - 5) * 8 +: 8] = exp_acc;
         if (sub)
            exp_fl[3:1] = {r >= exp_acc, r[3:0] >= exp_acc[3:0],
                           r == exp_acc};
         exp_fl[0] = sub;
         exp_rw = ((sub || swp) && w[7]) ? {1'b1, w[6:0], res} : 16'h0;
         if ((sub || swp) && !w[7])
            exp_acc = res;
      end
      q.push_back({exp_rw, exp_acc, exp_fl, exp_dir});
   endtask : step
   task automatic check(input logic [51:0] got);
      logic [51:0] e;
      e = q.pop_front();
      n_compared++;
      if (got !== e) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, e);
      end
   endtask : check
   task automatic tally_and_finish();
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge clock) seen <= q.size();
   always @(negedge clock) begin
      if (seen > 0)
         check({got_rw, acc, flags, flags_wr, dir_regs});
   end
   initial begin
      logic [13:0] w;
      void'($urandom(73221));
      foreach (u_rf.mem[i])
         u_rf.mem[i] = 8'($urandom);
      u_rf.mem[9] = 8'h00;
      u_rf.mem[11] = 8'h20;
      u_rf.mem[12] = 8'h01;
      u_rf.mem[13] = 8'h03;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      step(14'h0209, 1, 1, 0, 8'h00);
      step(14'h0e0b, 1, 1, 0, 8'h00);
      step(14'h028c, 1, 1, 0, 8'h00);
      step(14'h028d, 1, 1, 0, 8'h00);
      step(14'h0065, 1, 1, 1, 8'h3c);
      repeat (400) begin
         case ($urandom % 4)
            0: w = {6'h02, 8'($urandom)};
            1: w = {6'h0e, 8'($urandom)};
            2: w = 14'h0060 | 14'($urandom % 8);
            default: w = {6'h07, 8'($urandom)};
         endcase
         step(w, $urandom % 8 != 0, $urandom % 8 != 0, 1'($urandom),
              8'($urandom));
      end
      repeat (2) @(posedge clock);
      tally_and_finish();
   end
endmodule : subtract_swap_direction_ops_tb
